// [hdl/rsfc_pkg.sv]
package rsfc_pkg;

  // command codes of the byte-wide register map
  localparam logic [7:0] RANGE_POLARITY_CONFIG_ADDR    = 8'h1D;
  localparam logic [7:0] BROADCAST_REFRESH_CMD_ADDR    = 8'h1E;
  localparam logic [7:0] RESULTS_ONLY_REFRESH_CMD_ADDR = 8'h1F;
  localparam logic [7:0] RATE_PIN_TRACKING_ADDR        = 8'h20;

  // range_polarity_config layout: channel 1 in the highest pair
  localparam int SENSE_FIELD_LSB = 8;
  localparam int BUS_FIELD_LSB   = 0;
  localparam int FIELD_W         = 2;
  localparam int CHANNELS        = 4;

  // polarity codes
  localparam logic [1:0] POL_UNIPOLAR  = 2'h0;
  localparam logic [1:0] POL_BIPOLAR   = 2'h1;
  localparam logic [1:0] POL_BIP_HALF  = 2'h2;
  localparam logic [1:0] POL_RESERVED  = 2'h3;

  // rate_pin_tracking bit positions
  localparam int PIN_LEVEL_BIT   = 7;
  localparam int RISE_SEEN_BIT   = 6;
  localparam int FALL_SEEN_BIT   = 5;
  localparam int RISE_FULL_BIT   = 4;
  localparam int RISE_RES_BIT    = 3;
  localparam int FALL_FULL_BIT   = 2;
  localparam int FALL_RES_BIT    = 1;
  localparam int EDGE_EN_LSB     = 1;

  // reset values
  localparam logic [15:0] RANGE_RESET   = 16'h0000;
  localparam logic [3:0]  EDGE_EN_RESET = 4'h0;

  // settle time before refreshed results may be read
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int SETTLE_TIME_US  = 1000;
  localparam int SETTLE_CYC      = (SETTLE_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int SETTLE_W        = 18;

  // decoded serial command: read, write with data, or data-less send byte
  typedef struct packed {
    logic        valid;
    logic        rd;
    logic        send;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } rsfc_cmd_t;

  // refresh actions toward the measurement datapath
  typedef struct packed {
    logic latch_results;
    logic clear_accum;
    logic activate_ctrl;
  } rsfc_refresh_t;

  typedef struct packed {
    logic [2:0]          sync;
    logic                pin_lvl;
    logic                rise_seen;
    logic                fall_seen;
    logic [3:0]          edge_en;
    logic [15:0]         range_cfg;
    logic [15:0]         range_act;
    rsfc_refresh_t       act;
    logic [SETTLE_W-1:0] settle_cnt;
    logic                valid;
    logic [15:0]         rd_data;
    logic                rd_valid;
  } rsfc_state_t;

endpackage

// [hdl/rsfc_refresh_ctrl.sv]
// Operation
// - range register bits 15:8 hold four sense polarity fields, channel 1 highest
// - bits 7:0 hold four bus polarity fields: unipolar, bipolar 32 V, bipolar 16 V
// - sense code 10 selects half span bipolar, code 11 reserved
// - send byte at 1EH is the broadcast refresh, executed on receipt
// - broadcast refresh latches results and clears accumulators like full refresh
// - refreshed data valid from 1 ms until the next refresh
// - send byte at 1FH latches results, accumulators keep running
// - result-only refresh data readable from 1 ms, stable until next refresh
// - bit 7 at 20H reads the present rate pin level
// - bit 6 sets on rising pin edge, cleared only by full refresh
// - bit 5 sets on falling pin edge, cleared only by full refresh
// - bit 4 enables limited full refresh on rising edge
// - bit 3 enables limited result-only refresh on rising edge
// - bit 2 enables limited full refresh on falling edge
// - bit 1 enables limited result-only refresh on falling edge
// - edge enable bits never clear themselves
// - limited refresh latches results but activates no pending control
// - only limited full refresh clears accumulators and count
// - full wins when both limited refreshes are enabled for one edge
// - rate pin register writes and reads act live
// - rate pin is asynchronous to the serial bus
// - bit 0 at 20H ignores writes and reads zero
`timescale 1ns/1ps

module rsfc_refresh_ctrl #(
  parameter int unsigned SETTLE_CYCLES = rsfc_pkg::SETTLE_CYC
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // decoded serial commands
  input  wire rsfc_pkg::rsfc_cmd_t   cmd,
  input  wire logic                  full_refresh_req,
  output logic [15:0]                rd_data,
  output logic                       rd_valid,
  // rate-override pin
  input  wire logic                  rate_pin,
  // toward the measurement datapath
  output rsfc_pkg::rsfc_refresh_t    refresh,
  output logic [15:0]                latched_range_image,
  output logic                       results_valid
);

  localparam rsfc_pkg::rsfc_state_t ST_RESET = '{
    sync:       3'h0,
    pin_lvl:    1'b0,
    rise_seen:  1'b0,
    fall_seen:  1'b0,
    edge_en:    rsfc_pkg::EDGE_EN_RESET,
    range_cfg:  rsfc_pkg::RANGE_RESET,
    range_act:  rsfc_pkg::RANGE_RESET,
    act:        3'h0,
    settle_cnt: '0,
    valid:      1'b0,
    rd_data:    16'h0000,
    rd_valid:   1'b0
  };

  localparam logic [rsfc_pkg::SETTLE_W-1:0] SETTLE_LAST =
    rsfc_pkg::SETTLE_W'(SETTLE_CYCLES - 1);

  rsfc_pkg::rsfc_state_t st_r;
  rsfc_pkg::rsfc_state_t st_nxt;

  logic pin_rise;
  logic pin_fall;
  logic wr_hit_range;
  logic wr_hit_pin;
  logic bcast_cmd;
  logic resonly_cmd;
  logic full_cmd;
  logic lim_full;
  logic lim_res;

  function automatic logic wr_at(input rsfc_pkg::rsfc_cmd_t c,
                                 input logic [7:0] a);
    wr_at = c.valid && !c.rd && !c.send && (c.addr == a);
  endfunction

  function automatic logic send_at(input rsfc_pkg::rsfc_cmd_t c,
                                   input logic [7:0] a);
    send_at = c.valid && c.send && (c.addr == a);
  endfunction

  function automatic logic [15:0] pin_reg(input rsfc_pkg::rsfc_state_t s);
    pin_reg = 16'h0000;
    pin_reg[rsfc_pkg::PIN_LEVEL_BIT] = s.pin_lvl;
    pin_reg[rsfc_pkg::RISE_SEEN_BIT] = s.rise_seen;
    pin_reg[rsfc_pkg::FALL_SEEN_BIT] = s.fall_seen;
    pin_reg[rsfc_pkg::EDGE_EN_LSB +: 4] = s.edge_en;
  endfunction

  // a level change counts only once stages two and three agree
  assign pin_rise = (st_r.sync[1] == st_r.sync[2]) && st_r.sync[2]
                    && !st_r.pin_lvl;
  assign pin_fall = (st_r.sync[1] == st_r.sync[2]) && !st_r.sync[2]
                    && st_r.pin_lvl;

  assign wr_hit_range = wr_at(cmd, rsfc_pkg::RANGE_POLARITY_CONFIG_ADDR);
  assign wr_hit_pin   = wr_at(cmd, rsfc_pkg::RATE_PIN_TRACKING_ADDR);
  assign bcast_cmd    = send_at(cmd, rsfc_pkg::BROADCAST_REFRESH_CMD_ADDR);
  assign resonly_cmd  = send_at(cmd, rsfc_pkg::RESULTS_ONLY_REFRESH_CMD_ADDR);
  assign full_cmd     = full_refresh_req || bcast_cmd;

  // full beats result-only on the same edge
  assign lim_full = (pin_rise && st_r.edge_en[rsfc_pkg::RISE_FULL_BIT - 1])
                 || (pin_fall && st_r.edge_en[rsfc_pkg::FALL_FULL_BIT - 1]);
  assign lim_res  = !lim_full &&
                   ((pin_rise && st_r.edge_en[rsfc_pkg::RISE_RES_BIT - 1])
                 || (pin_fall && st_r.edge_en[rsfc_pkg::FALL_RES_BIT - 1]));

  always_comb begin
    st_nxt = st_r;

    // three-stage synchroniser; stage one feeds only stage two
    st_nxt.sync = {st_r.sync[1], st_r.sync[0], rate_pin};
    if (pin_rise || pin_fall) begin
      st_nxt.pin_lvl = st_r.sync[2];
    end

    // sticky edge flags; an edge in a clearing cycle still sets
    if (full_cmd) begin
      st_nxt.rise_seen = 1'b0;
      st_nxt.fall_seen = 1'b0;
    end
    if (pin_rise) begin
      st_nxt.rise_seen = 1'b1;
    end
    if (pin_fall) begin
      st_nxt.fall_seen = 1'b1;
    end

    // enables change only by a host write, bit 0 not stored
    if (wr_hit_pin) begin
      st_nxt.edge_en = cmd.wdata[rsfc_pkg::EDGE_EN_LSB +: 4];
    end

    // range writes stay pending until a commanded full refresh
    if (wr_hit_range) begin
      st_nxt.range_cfg = cmd.wdata;
    end
    if (full_cmd) begin
      st_nxt.range_act = st_r.range_cfg;
    end

    // refresh action pulses
    st_nxt.act.latch_results = full_cmd || resonly_cmd
                               || lim_full || lim_res;
    st_nxt.act.clear_accum   = full_cmd || lim_full;
    st_nxt.act.activate_ctrl = full_cmd;

    // results settle window restarts on every refresh of any kind
    if (st_nxt.act.latch_results) begin
      st_nxt.settle_cnt = '0;
      st_nxt.valid      = 1'b0;
    end else if (!st_r.valid) begin
      if (st_r.settle_cnt == SETTLE_LAST) begin
        st_nxt.valid = 1'b1;
      end else begin
        st_nxt.settle_cnt = st_r.settle_cnt + 1'b1;
      end
    end

    // register reads answer one cycle later, unmapped reads give zero
    st_nxt.rd_valid = cmd.valid && cmd.rd;
    if (cmd.valid && cmd.rd) begin
      unique case (cmd.addr)
        rsfc_pkg::RANGE_POLARITY_CONFIG_ADDR: begin
          st_nxt.rd_data = st_r.range_cfg;
        end
        rsfc_pkg::RATE_PIN_TRACKING_ADDR: begin
          st_nxt.rd_data = pin_reg(st_r);
        end
        default: begin
          st_nxt.rd_data = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data             = st_r.rd_data;
  assign rd_valid            = st_r.rd_valid;
  assign refresh             = st_r.act;
  assign latched_range_image = st_r.range_act;
  assign results_valid       = st_r.valid;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_rise_flag_set: assert property
    (pin_rise |=> st_r.rise_seen)
    else $error("rise flag not set after rising edge");

  a_fall_flag_set: assert property
    (pin_fall |=> st_r.fall_seen)
    else $error("fall flag not set after falling edge");

  a_flag_clear: assert property
    (full_cmd && !pin_rise && !pin_fall
     |=> !st_r.rise_seen && !st_r.fall_seen)
    else $error("edge flags not cleared by full refresh");

  a_rise_set_wins: assert property
    (pin_rise && full_cmd |=> st_r.rise_seen)
    else $error("rise flag lost to a clear");

  a_fall_set_wins: assert property
    (pin_fall && full_cmd |=> st_r.fall_seen)
    else $error("fall flag lost to a clear");

  a_rise_sticky: assert property
    (st_r.rise_seen && !full_cmd |=> st_r.rise_seen)
    else $error("rise flag dropped without refresh");

  a_fall_sticky: assert property
    (st_r.fall_seen && !full_cmd |=> st_r.fall_seen)
    else $error("fall flag dropped without refresh");

  a_bcast_full: assert property
    (bcast_cmd |=> refresh.latch_results && refresh.clear_accum
                   && refresh.activate_ctrl)
    else $error("broadcast refresh incomplete");

  a_resonly_keeps: assert property
    (resonly_cmd && !full_cmd && !lim_full
     |=> refresh.latch_results && !refresh.clear_accum)
    else $error("result-only refresh cleared accumulators");

  a_rise_full_ref: assert property
    (pin_rise && st_r.edge_en[3] && !full_cmd
     |=> refresh.clear_accum && !refresh.activate_ctrl)
    else $error("limited full refresh wrong on rising edge");

  a_rise_res_ref: assert property
    (pin_rise && st_r.edge_en[2] && !st_r.edge_en[3] && !full_cmd
     |=> refresh.latch_results && !refresh.clear_accum)
    else $error("limited result-only refresh wrong on rising edge");

  a_fall_full_ref: assert property
    (pin_fall && st_r.edge_en[1] && !full_cmd
     |=> refresh.clear_accum && !refresh.activate_ctrl)
    else $error("limited full refresh wrong on falling edge");

  a_fall_res_ref: assert property
    (pin_fall && st_r.edge_en[0] && !st_r.edge_en[1] && !full_cmd
     |=> refresh.latch_results && !refresh.clear_accum)
    else $error("limited result-only refresh wrong on falling edge");

  a_both_full_win: assert property
    (pin_rise && st_r.edge_en[3] && st_r.edge_en[2] |=> refresh.clear_accum)
    else $error("full refresh lost when both enabled");

  a_fall_both_win: assert property
    (pin_fall && st_r.edge_en[1] && st_r.edge_en[0] |=> refresh.clear_accum)
    else $error("full refresh lost when both enabled on fall");

  a_no_edge_ref: assert property
    (pin_rise && st_r.edge_en[3:2] == 2'h0 && !full_cmd && !resonly_cmd
     |=> !refresh.latch_results)
    else $error("refresh on disabled rising edge");

  a_no_fall_ref: assert property
    (pin_fall && st_r.edge_en[1:0] == 2'h0 && !full_cmd && !resonly_cmd
     |=> !refresh.latch_results)
    else $error("refresh on disabled falling edge");

  a_lim_no_act: assert property
    ((lim_full || lim_res) && !full_cmd
     |=> !refresh.activate_ctrl && $stable(latched_range_image))
    else $error("limited refresh activated pending control");

  a_lim_res_acc: assert property
    (lim_res && !full_cmd |=> refresh.latch_results && !refresh.clear_accum)
    else $error("limited result-only refresh cleared accumulators");

  a_enable_hold: assert property
    (!wr_hit_pin |=> $stable(st_r.edge_en))
    else $error("edge enables changed without write");

  a_enable_write: assert property
    (wr_hit_pin
     |=> st_r.edge_en == $past(cmd.wdata[rsfc_pkg::EDGE_EN_LSB +: 4]))
    else $error("edge enable write not taken at once");

  a_range_store: assert property
    (wr_hit_range |=> st_r.range_cfg == $past(cmd.wdata))
    else $error("range write not stored");

  a_range_pending: assert property
    (wr_hit_range && !full_cmd |=> $stable(latched_range_image))
    else $error("range write activated without refresh");

  a_range_commit: assert property
    (full_cmd |=> latched_range_image == $past(st_r.range_cfg))
    else $error("full refresh did not activate range");

  a_send_no_store: assert property
    (cmd.valid && cmd.send
     |=> $stable(st_r.range_cfg) && $stable(st_r.edge_en))
    else $error("send byte changed a register");

  a_valid_drop: assert property
    (refresh.latch_results |-> !results_valid ##1 !results_valid)
    else $error("results valid during settle window");

  a_valid_hold: assert property
    (results_valid && !st_nxt.act.latch_results |=> results_valid)
    else $error("results valid dropped without refresh");

  a_range_read: assert property
    (cmd.valid && cmd.rd && cmd.addr == rsfc_pkg::RANGE_POLARITY_CONFIG_ADDR
     |=> rd_valid && rd_data == $past(st_r.range_cfg))
    else $error("range register read wrong");

  a_pin_read: assert property
    (cmd.valid && cmd.rd && cmd.addr == rsfc_pkg::RATE_PIN_TRACKING_ADDR
     |=> rd_valid && rd_data[0] == 1'b0
         && rd_data[7] == $past(st_r.pin_lvl))
    else $error("rate pin register read wrong");

  a_cmd_read_zero: assert property
    (cmd.valid && cmd.rd && cmd.addr == rsfc_pkg::BROADCAST_REFRESH_CMD_ADDR
     |=> rd_valid && rd_data == 16'h0000)
    else $error("command code read not zero");

  a_level_track: assert property
    (pin_rise || pin_fall |=> st_r.pin_lvl == $past(st_r.sync[2]))
    else $error("pin level not tracked");

  a_sync_edge: assert property
    (pin_rise |=> !pin_rise)
    else $error("one pin edge counted twice");

  c_rise_refresh: cover property (pin_rise && st_r.edge_en[3]
    ##1 refresh.clear_accum);
  c_fall_refresh: cover property (pin_fall && st_r.edge_en[1]
    ##1 refresh.clear_accum);
  c_bcast: cover property (bcast_cmd ##1 refresh.activate_ctrl);
  c_resonly: cover property (resonly_cmd ##1 refresh.latch_results
    && !refresh.clear_accum);
  c_valid: cover property (refresh.latch_results ##[1:1000] results_valid);

endmodule // rsfc_refresh_ctrl

// [verification/rsfc_host_model.sv]
`timescale 1ns/1ps

module rsfc_host_model (
  // clock
  input  wire logic           sys_clk,
  // decoded serial commands
  output rsfc_pkg::rsfc_cmd_t cmd,
  output logic                full_refresh_req
);
  rsfc_pkg::rsfc_cmd_t idle;

  initial begin
    cmd = '0;
    full_refresh_req = 1'b0;
  end

  // held for one taking edge; idle fields flip so stale values never pass
  task automatic issue(input logic rd, input logic send,
                       input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    cmd <= '{1'b1, rd, send, a, d};
    @(posedge sys_clk);
    idle = ~cmd;
    idle.valid = 1'b0;
    cmd <= idle;
  endtask

  task automatic full();
    @(posedge sys_clk);
    full_refresh_req <= 1'b1;
    @(posedge sys_clk);
    full_refresh_req <= 1'b0;
  endtask
endmodule // rsfc_host_model

// [verification/refresh_slow_fsr_control_test.sv]
`timescale 1ns/1ps

module refresh_slow_fsr_control_test;
  localparam int SET = 20;
  logic                    sys_clk;
  logic                    rst;
  logic                    rate_pin;
  logic                    rd_valid;
  logic                    results_valid;
  logic                    full_refresh_req;
  logic [15:0]             rd_data;
  logic [15:0]             latched_range_image;
  logic [15:0]             rng;
  logic [15:0]             lat;
  rsfc_pkg::rsfc_cmd_t     cmd;
  rsfc_pkg::rsfc_refresh_t refresh;
  logic [15:0]             rd_q[$];
  rsfc_pkg::rsfc_refresh_t rf_q[$];
  int                      err_count = 0;
  int                      checks = 0;
  int                      seed = 3;
  int                      cyc = 0;
  int                      n;

  rsfc_host_model u_host (
    .sys_clk          (sys_clk),
    .cmd              (cmd),
    .full_refresh_req (full_refresh_req)
  );

  rsfc_refresh_ctrl #(.SETTLE_CYCLES(SET)) u_dut (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .cmd                 (cmd),
    .full_refresh_req    (full_refresh_req),
    .rd_data             (rd_data),
    .rd_valid            (rd_valid),
    .rate_pin            (rate_pin),
    .refresh             (refresh),
    .latched_range_image (latched_range_image),
    .results_valid       (results_valid)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic bad(input string what);
    err_count++;
    $display("ERROR %0t %s", $time, what);
  endtask

  task automatic cmp16(input logic [15:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    if (rd_q.size() + rf_q.size() != 0) begin
      bad("results missing");
    end
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // every result must match the oldest note; unexpected ones are errors
  always @(negedge sys_clk) begin
    if (rst === 1'b0 && rd_valid !== 1'b0) begin
      if (rd_q.size() == 0) bad("stray read");
      else cmp16(rd_data, rd_q.pop_front(), "read");
    end
    if (rst === 1'b0 && refresh !== 3'h0) begin
      if (rf_q.size() == 0) bad("stray refresh");
      else cmp16({13'h0, refresh}, {13'h0, rf_q.pop_front()}, "refresh");
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad("timeout");
      finish_test();
    end
  end

  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    u_host.issue(1'b1, 1'b0, a, 16'h0);
  endtask

  task automatic snd(input logic [7:0] a, input logic [2:0] e);
    if (e != 3'h0) rf_q.push_back(e);
    u_host.issue(1'b0, 1'b1, a, 16'($random(seed)));
  endtask

  // one pulse per edge at most; full outranks result-only
  task automatic pin(input logic v, input logic full_en, res_en);
    if (full_en) rf_q.push_back(3'h6);
    else if (res_en) rf_q.push_back(3'h4);
    @(posedge sys_clk);
    rate_pin <= v;
    idle(8);
  endtask

  task automatic settle();
    n = 0;
    // skip the launching edge so a stale valid level never ends the wait
    @(negedge sys_clk);
    while (results_valid !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    cmp16(16'(n >= SET && n <= SET + 3), 16'h1, "settle time");
  endtask

  initial begin
    rst = 1'b1;
    rate_pin = 1'b0;
    lat = 16'h0000;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h1D, 16'h0000);
    rd(8'h20, 16'h0000);
    rd(8'h1E, 16'h0000);
    u_host.issue(1'b0, 1'b0, 8'h1E, 16'hFFFF);
    snd(8'h1D, 3'h0);
    for (int i = 0; i < 4; i++) begin
      rng = 16'($random(seed));
      u_host.issue(1'b0, 1'b0, 8'h1D, rng);
      rd(8'h1D, rng);
      snd(8'h1F, 3'h4);
      settle();
      cmp16(latched_range_image, lat, "pending range");
      snd(8'h1E, 3'h7);
      settle();
      lat = rng;
      cmp16(latched_range_image, lat, "active range");
    end
    // every enable combination against both pin edges
    for (int e = 0; e < 16; e++) begin
      rng = 16'($random(seed));
      u_host.issue(1'b0, 1'b0, 8'h20, {rng[15:5], e[3:0], rng[0]});
      rd(8'h20, {8'h00, 3'b000, e[3:0], 1'b0});
      pin(1'b1, e[3], e[2]);
      rd(8'h20, {8'h00, 3'b110, e[3:0], 1'b0});
      pin(1'b0, e[1], e[0]);
      rd(8'h20, {8'h00, 3'b011, e[3:0], 1'b0});
      cmp16(latched_range_image, lat, "limited refresh");
      if (e[0]) begin
        snd(8'h1E, 3'h7);
      end else begin
        rf_q.push_back(3'h7);
        u_host.full();
      end
      idle(4);
    end
    idle(10);
    finish_test();
  end
endmodule // refresh_slow_fsr_control_test
